/* File: bfcs_pkg.sv */
// Package: register map, pin timing and types for the flash pin controller
package bfcs_pkg;

  // ----------------------------------------------------------------
  // Clock and pin timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int T_SETUP_NS = 50;   // Address/data setup before write strobe
  localparam int T_WE_LOW_NS = 100; // Write strobe low width
  localparam int T_HOLD_NS = 50;    // Address/data hold after strobe rises
  localparam int T_ACC_NS = 200;    // Read access before sampling
  localparam int T_WAKE_NS = 1000;  // wake_to_write_time
  localparam int T_ROV_NS = 1000;   // reset_to_output_valid_time
  localparam int T_PD_NS = 1000;    // Least low time of the power-down pin

  // Least times round up to whole cycles, never below one
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] C_SETUP = CNT_W'(ns2cyc(T_SETUP_NS));
  localparam logic [CNT_W-1:0] C_WE_LOW = CNT_W'(ns2cyc(T_WE_LOW_NS));
  localparam logic [CNT_W-1:0] C_HOLD = CNT_W'(ns2cyc(T_HOLD_NS));
  localparam logic [CNT_W-1:0] C_ACC = CNT_W'(ns2cyc(T_ACC_NS) + 3);
  localparam logic [CNT_W-1:0] C_WAKE = CNT_W'(ns2cyc(T_WAKE_NS));
  localparam logic [CNT_W-1:0] C_ROV = CNT_W'(ns2cyc(T_ROV_NS));
  localparam logic [CNT_W-1:0] C_PD = CNT_W'(ns2cyc(T_PD_NS));

  // ----------------------------------------------------------------
  // Array geometry and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 21;  // Widest density option
  localparam int DATA_W = 8;
  localparam int PADDR_W = 8;
  localparam logic [PADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [PADDR_W-1:0] OFS_ADDR = 8'h04;
  localparam logic [PADDR_W-1:0] OFS_WDATA = 8'h08;
  localparam logic [PADDR_W-1:0] OFS_CMD = 8'h0C;
  localparam logic [PADDR_W-1:0] OFS_STATUS = 8'h10;
  localparam logic [PADDR_W-1:0] OFS_RDATA = 8'h14;
  localparam int CTRL_PD_BIT = 0;
  localparam int CTRL_HH_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_RDY_BIT = 1;
  localparam int ST_WOK_BIT = 2;
  localparam int ST_ROK_BIT = 3;
  localparam int ST_REF_BIT = 4;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WAIT = 2'h3;

  // Pin bundle toward the flash
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe_n;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic powerdown_reset_in;
    logic high_programming_voltage;
  } bfcs_pins_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_WSET = 7'h02,
    ST_WLOW = 7'h04,
    ST_WHLD = 7'h08,
    ST_RACC = 7'h10,
    ST_RDON = 7'h20,
    ST_WRDY = 7'h40
  } bfcs_state_t;

endpackage : bfcs_pkg

/* File: bfcs_ctrl.sv */
// Host-side controller that drives a block flash through its pins
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Automation starts only from command sequences written as bus cycles.
// - Host learns completion by polling status or waiting on ready/busy.
// - After reset pin rises, host waits before trusting read data.
// - After reset pin rises, host issues no write before the wake delay.
module bfcs_ctrl
  import bfcs_pkg::*;
(
  input wire logic pclk,                   // APB clock, 20 MHz
  input wire logic presetn,                // Async reset, active low
  input wire logic psel,                   // APB select
  input wire logic penable,                // APB access phase
  input wire logic pwrite,                 // APB direction
  input wire logic [PADDR_W-1:0] paddr,    // APB byte address
  input wire logic [31:0] pwdata,          // APB write data
  output logic [31:0] prdata,              // APB read data
  output logic pready,                     // APB ready
  output logic pslverr,                    // APB error, unmapped address
  output bfcs_pins_t pins,                 // Pins toward the flash
  input wire logic [DATA_W-1:0] dq_in,     // Data pins as read back
  input wire logic ready_busy_out          // Device ready/busy pin
);

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] rdy_s_q;
  logic [DATA_W-1:0] dq_s1_q, dq_s2_q, dq_s3_q;
  logic rdy_q;

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_s_q <= 3'h0;
      rdy_q <= 1'b0;
    end else begin
      rdy_s_q <= {rdy_s_q[1:0], ready_busy_out};
      if (rdy_s_q[1] == rdy_s_q[2]) rdy_q <= rdy_s_q[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
      dq_s3_q <= 8'h00;
    end else begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // APB slave and own registers
  // ----------------------------------------------------------------
  logic [1:0] ctrl_q;
  logic [ADDR_W-1:0] addr_reg_q;
  logic [DATA_W-1:0] wdata_q, rdata_q;
  logic refused_q;
  logic wok_q, rok_q;
  bfcs_state_t state_q;
  logic apb_wr, apb_rd, cmd_wr, mapped, cmd_ok, start;
  logic [1:0] cmd_op;
  logic [31:0] rd_mux;

  assign apb_wr = psel && penable && pready && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign cmd_wr = apb_wr && (paddr == OFS_CMD);
  assign cmd_op = pwdata[1:0];
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_ADDR) ||
                  (paddr == OFS_WDATA) || (paddr == OFS_CMD) ||
                  (paddr == OFS_STATUS) || (paddr == OFS_RDATA);

  // Writes wait for the wake delay, reads for the output-valid delay
  always_comb begin
    unique case (cmd_op)
      OP_WRITE: cmd_ok = wok_q;
      OP_READ: cmd_ok = rok_q;
      OP_WAIT: cmd_ok = ctrl_q[CTRL_PD_BIT] == 1'b0;
      default: cmd_ok = 1'b0;
    endcase
  end
  assign start = cmd_wr && (state_q == ST_IDLE) && cmd_ok;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL: rd_mux = {30'h0, ctrl_q};
      OFS_ADDR: rd_mux = {11'h000, addr_reg_q};
      OFS_WDATA: rd_mux = {24'h00_0000, wdata_q};
      OFS_STATUS: rd_mux = {27'h0, refused_q, rok_q, wok_q, rdy_q,
                            state_q != ST_IDLE};
      OFS_RDATA: rd_mux = {24'h00_0000, rdata_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Zero-wait slave: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (apb_rd) prdata <= rd_mux;
    end
  end

  // Software-owned control words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      addr_reg_q <= 21'h00_0000;
      wdata_q <= 8'h00;
    end else if (apb_wr) begin
      if (paddr == OFS_CTRL) ctrl_q <= pwdata[1:0];
      if (paddr == OFS_ADDR) addr_reg_q <= pwdata[ADDR_W-1:0];
      if (paddr == OFS_WDATA) wdata_q <= pwdata[DATA_W-1:0];
    end
  end

  // Sticky refusal flag; a new refusal beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_q <= 1'b0;
    end else if (cmd_wr && !start) begin
      refused_q <= 1'b1;
    end else if (apb_wr && paddr == OFS_STATUS && pwdata[ST_REF_BIT]) begin
      refused_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power-down and wake timing
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] pd_cnt_q, wake_cnt_q, rov_cnt_q;
  logic pd_pin_q;

  // Pin held low a least time, even if software releases at once; the
  // wake counters restart on every release so stale readiness never leaks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_pin_q <= 1'b0;
      pd_cnt_q <= 12'h000;
      wake_cnt_q <= 12'h000;
      rov_cnt_q <= 12'h000;
      wok_q <= 1'b0;
      rok_q <= 1'b0;
    end else if (ctrl_q[CTRL_PD_BIT] || pd_cnt_q < C_PD) begin
      pd_pin_q <= 1'b0;
      if (ctrl_q[CTRL_PD_BIT]) pd_cnt_q <= 12'h000;
      else pd_cnt_q <= pd_cnt_q + 12'h001;
      wake_cnt_q <= 12'h000;
      rov_cnt_q <= 12'h000;
      wok_q <= 1'b0;
      rok_q <= 1'b0;
    end else begin
      pd_pin_q <= 1'b1;
      if (wake_cnt_q < C_WAKE) wake_cnt_q <= wake_cnt_q + 12'h001;
      else wok_q <= 1'b1;
      if (rov_cnt_q < C_ROV) rov_cnt_q <= rov_cnt_q + 12'h001;
      else rok_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 12'h000;
    end else if (ctrl_q[CTRL_PD_BIT]) begin
      state_q <= ST_IDLE;  // Power-down aborts any cycle in flight
      cnt_q <= 12'h000;
    end else begin
      cnt_q <= cnt_q + 12'h001;
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= 12'h000;
          if (start) begin
            unique case (cmd_op)
              OP_WRITE: state_q <= ST_WSET;
              OP_READ: state_q <= ST_RACC;
              default: state_q <= ST_WRDY;
            endcase
          end
        end
        ST_WSET: if (cnt_q + 12'h001 >= C_SETUP) begin
          state_q <= ST_WLOW;
          cnt_q <= 12'h000;
        end
        ST_WLOW: if (cnt_q + 12'h001 >= C_WE_LOW) begin
          state_q <= ST_WHLD;
          cnt_q <= 12'h000;
        end
        ST_WHLD: if (cnt_q + 12'h001 >= C_HOLD) begin
          state_q <= ST_IDLE;
        end
        ST_RACC: if (cnt_q + 12'h001 >= C_ACC) begin
          state_q <= ST_RDON;
        end
        ST_RDON: state_q <= ST_IDLE;
        ST_WRDY: if (rdy_q) begin
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Read data taken once access time plus synchroniser delay has passed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 8'h00;
    end else if (state_q == ST_RACC && cnt_q + 12'h001 >= C_ACC &&
                 dq_s2_q == dq_s3_q) begin
      rdata_q <= dq_s3_q;
    end
  end

  // Pin drive; address and data stay steady across the strobe's rising
  // edge, and chip select is released between cycles to allow standby, except when a command starts in the first idle cycle after a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins.addr <= 21'h00_0000;
      pins.dq_out <= 8'h00;
      pins.dq_oe_n <= 1'b1;
      pins.ce_n <= 1'b1;
      pins.oe_n <= 1'b1;
      pins.we_n <= 1'b1;
    end else begin
      pins.ce_n <= 1'b1;
      pins.oe_n <= 1'b1;
      pins.we_n <= 1'b1;
      pins.dq_oe_n <= 1'b1;
      if (start) begin
        pins.addr <= addr_reg_q;
        pins.dq_out <= wdata_q;
      end
      if (!ctrl_q[CTRL_PD_BIT]) begin
        unique case (state_q)
          ST_WSET, ST_WHLD: begin
            pins.ce_n <= 1'b0;
            pins.dq_oe_n <= 1'b0;
          end
          ST_WLOW: begin
            pins.ce_n <= 1'b0;
            pins.dq_oe_n <= 1'b0;
            pins.we_n <= 1'b0;
          end
          ST_RACC: begin
            pins.ce_n <= 1'b0;
            pins.oe_n <= 1'b0;
          end
          default: begin
          end
        endcase
        if (start && cmd_op == OP_WRITE) begin
          pins.ce_n <= 1'b0;
          pins.dq_oe_n <= 1'b0;
        end
        if (start && cmd_op == OP_READ) begin
          pins.ce_n <= 1'b0;
          pins.oe_n <= 1'b0;
        end
      end
    end
  end

  // Reset pin and high-voltage request; the override is only honoured
  // while the pin is released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins.powerdown_reset_in <= 1'b0;
      pins.high_programming_voltage <= 1'b0;
    end else begin
      pins.powerdown_reset_in <= pd_pin_q;
      pins.high_programming_voltage <= pd_pin_q &&
                                       ctrl_q[CTRL_HH_BIT];
    end
  end

endmodule // bfcs_ctrl

`default_nettype wire

/* File: bfcs_ctrl_props.sv */
// Assertion checker for the flash pin controller
`timescale 1ns/10ps
`default_nettype none
module bfcs_ctrl_props
  import bfcs_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Access phase
  input wire logic pwrite, // Direction
  input wire logic [PADDR_W-1:0] paddr, // Byte address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire bfcs_pins_t pins, // Flash pins
  input wire logic [DATA_W-1:0] dq_in, // Data read back
  input wire logic ready_busy_out // Device ready
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Time since the reset pin last moved
  // ----------------------------------------------------------------
  logic [11:0] run_q;
  logic pd_q;
  // Saturates so a long run never wraps back under the wake figure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= '0;
      pd_q <= 1'b0;
    end else begin
      pd_q <= pins.powerdown_reset_in;
      if (pins.powerdown_reset_in != pd_q) begin
        run_q <= '0;
      end else if (run_q != 12'hFFF) begin
        run_q <= run_q + 12'h001;
      end
    end
  end
  chk_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_unmapped_err: assert property (psel && penable && pready &&
    paddr > 8'h14 |-> pslverr) else $error("unmapped access not flagged");
  chk_strobe_shape: assert property ($fell(pins.we_n) |->
    !pins.ce_n && !pins.dq_oe_n ##1 !pins.we_n ##1 pins.we_n)
    else $error("write strobe shape wrong");
  chk_latch_held: assert property ($rose(pins.we_n) |->
    !pins.ce_n && !pins.dq_oe_n && $stable(pins.addr) &&
    $stable(pins.dq_out)) else $error("address or data moved at strobe");
  chk_write_gate: assert property ($fell(pins.we_n) |->
    pins.powerdown_reset_in && run_q >= C_WAKE)
    else $error("write before wake delay");
  chk_read_gate: assert property ($fell(pins.oe_n) |->
    pins.powerdown_reset_in && run_q >= C_ROV)
    else $error("read before output valid delay");
  chk_no_fight: assert property (!pins.oe_n |-> pins.dq_oe_n)
    else $error("data driven during read");
  chk_addr_still: assert property (
    !pins.oe_n && $past(!pins.oe_n) |-> $stable(pins.addr))
    else $error("address moved during read");
  cov_strobe: cover property ($rose(pins.we_n));
  cov_read: cover property ($fell(pins.oe_n));
  cov_err: cover property (pready && pslverr);
  cov_wake: cover property ($rose(pins.powerdown_reset_in));
endmodule // bfcs_ctrl_props
bind bfcs_ctrl bfcs_ctrl_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins(pins), .dq_in(dq_in),
  .ready_busy_out(ready_busy_out));
`default_nettype wire

/* File: bfcs_flash_model.sv */
// Behavioural model of the block flash behind the pins
`timescale 1ns/10ps
`default_nettype none
module bfcs_flash_model
  import bfcs_pkg::*;
#(
  parameter int BUSY_NS = 1000,
  parameter logic [7:0] CMD_PROG = 8'h40,
  parameter logic [7:0] CMD_ERASE = 8'h20,
  parameter logic [7:0] CMD_CONF = 8'hD0,
  parameter logic [7:0] CMD_ARR = 8'hFF,
  parameter logic [7:0] STAT_RDY = 8'h80,
  parameter logic [7:0] CMD_LOCK = 8'h60,
  parameter logic [7:0] CMD_LOCK_SET = 8'h01,
  parameter bit MASTER_LOCK = 1'b0
)
(
  input wire bfcs_pins_t pins, // Pins from the controller
  output logic [DATA_W-1:0] dq, // Data toward the controller
  output logic ready_busy_out // High when ready
);
  // ----------------------------------------------------------------
  // Array: 16 bytes kept per 64-Kbyte block
  // ----------------------------------------------------------------
  logic [7:0] mem [0:511]; // 32 blocks cover the widest option
  logic [31:0] lock_q;
  logic locked;
  logic [7:0] pend;
  logic stat_mode;
  logic [7:0] junk;
  time up_t;
  // Start erased and ready
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    lock_q = 32'h0000_0000;
    locked = 1'b0;
    pend = 8'h00;
    stat_mode = 1'b0;
    junk = 8'hA5;
    up_t = 0;
    ready_busy_out = 1'b1;
  end
  // Released bus keeps moving so stale data never looks valid
  always #35 junk = ~{junk[6:0], junk[7]};
  // Busy pulse of the internal state machine
  task automatic run_busy;
    fork
      begin
        ready_busy_out = 1'b0;
        #BUSY_NS;
        ready_busy_out = 1'b1;
      end
    join_none
  endtask
  // Power-down resets automation and status
  always @(negedge pins.powerdown_reset_in) begin
    pend = 8'h00;
    stat_mode = 1'b0;
    ready_busy_out = 1'b1;
  end
  always @(posedge pins.powerdown_reset_in) up_t = $time;
  // Commands latch on the strobe's rising edge
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.powerdown_reset_in && ready_busy_out
        && $time - up_t >= T_WAKE_NS) begin
      // Lock bit gates change unless the reset pin is at high voltage
      locked = lock_q[pins.addr[20:16]] &&
               !pins.high_programming_voltage;
      if (pend == CMD_PROG) begin
        if (!locked) begin
          mem[{pins.addr[20:16], pins.addr[3:0]}] &= pins.dq_out;
        end
        pend = 8'h00;
        run_busy();
      end else if (pend == CMD_ERASE && pins.dq_out == CMD_CONF) begin
        for (int i = 0; i < 16; i++) begin
          if (!locked) mem[{pins.addr[20:16], i[3:0]}] = 8'hFF;
        end
        pend = 8'h00;
        run_busy();
      end else if (pend == CMD_LOCK && pins.dq_out == CMD_LOCK_SET) begin
        if (!MASTER_LOCK || pins.high_programming_voltage) begin
          lock_q[pins.addr[20:16]] = 1'b1;
        end
        pend = 8'h00;
        run_busy();
      end else begin
        pend = pins.dq_out;
        stat_mode = (pins.dq_out != CMD_ARR);
      end
    end
  end
  // Read path: status or array while selected and enabled
  assign dq = (!pins.ce_n && !pins.oe_n && pins.powerdown_reset_in) ?
    (stat_mode ? (ready_busy_out ? STAT_RDY : 8'h00)
    : mem[{pins.addr[20:16], pins.addr[3:0]}]) : junk;
endmodule // bfcs_flash_model
`default_nettype wire

/* File: bfcs_ctrl_tb.sv */
// Self-checking testbench for the flash pin controller
`timescale 1ns/10ps
`default_nettype none
module bfcs_ctrl_tb;
  import bfcs_pkg::*;
  // ----------------------------------------------------------------
  // Bench wiring
  // ----------------------------------------------------------------
  localparam logic [7:0] K_PROG = 8'h40;
  localparam logic [7:0] K_ERASE = 8'h20;
  localparam logic [7:0] K_CONF = 8'hD0;
  localparam logic [7:0] K_ARR = 8'hFF;
  localparam logic [7:0] K_RDY = 8'h80;
  localparam logic [7:0] K_LOCK = 8'h60;
  localparam logic [7:0] K_SET = 8'h01;
  localparam logic [20:0] A0 = 21'h00005;
  localparam logic [20:0] A1 = 21'h10005;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, rb;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  bfcs_pins_t pins;
  logic [DATA_W-1:0] dq_in, fl_dq;
  int errors, n_compared;
  // Data wire: controller wins while its enable is low
  assign dq_in = pins.dq_oe_n ? fl_dq : pins.dq_out;
  bfcs_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .dq_in(dq_in), .ready_busy_out(rb));
  bfcs_flash_model #(.CMD_PROG(K_PROG), .CMD_ERASE(K_ERASE),
    .CMD_CONF(K_CONF), .CMD_ARR(K_ARR), .STAT_RDY(K_RDY),
    .CMD_LOCK(K_LOCK), .CMD_LOCK_SET(K_SET), .MASTER_LOCK(1'b0)) fl (
    .pins(pins), .dq(fl_dq), .ready_busy_out(rb));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tmo(input logic ok);
    if (!ok) begin
      errors++;
      stop_test();
    end
  endtask
  // One bus transfer; an idle cycle follows so psel is never re-driven
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    tmo(pready === 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (r[b] !== v && n < 200);
    tmo(r[b] === v);
  endtask
  task automatic fop(input logic [20:0] a, input logic [7:0] d);
    apb(1'b1, OFS_ADDR, 32'(a));
    apb(1'b1, OFS_WDATA, 32'(d));
    apb(1'b1, OFS_CMD, 32'h1);
    poll(ST_BUSY_BIT, 1'b0);
  endtask
  task automatic rdy;
    apb(1'b1, OFS_CMD, 32'h3);
    poll(ST_BUSY_BIT, 1'b0);
  endtask
  task automatic frd(input logic [20:0] a, input logic [7:0] x);
    apb(1'b1, OFS_ADDR, 32'(a));
    apb(1'b1, OFS_CMD, 32'h2);
    poll(ST_BUSY_BIT, 1'b0);
    apb(1'b0, OFS_RDATA, 32'h0);
    chk(r, 32'(x));
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    n_compared = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'({pins.ce_n, pins.we_n, pins.powerdown_reset_in}), 32'h6);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(r[3:2]), 32'h0);
    apb(1'b1, OFS_CMD, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(r[ST_REF_BIT]), 32'h1);
    apb(1'b1, OFS_STATUS, 32'h10);
    poll(ST_WOK_BIT, 1'b1);
    poll(ST_ROK_BIT, 1'b1);
    chk(32'(r[ST_REF_BIT]), 32'h0);
    $display("test wake done");
    fop(A0, K_PROG);
    fop(A0, 8'h5A);
    poll(ST_RDY_BIT, 1'b0);
    rdy();
    chk(32'(r[ST_RDY_BIT]), 32'h1);
    frd(A0, K_RDY);
    fop(A0, K_ARR);
    frd(A0, 8'h5A);
    $display("test program done");
    fop(A1, K_PROG);
    fop(A1, 8'h33);
    rdy();
    fop(A0, K_ARR);
    frd(A1, 8'h33);
    fop(A1 ^ 21'h00009, K_ERASE);
    fop(A1 ^ 21'h00009, K_CONF);
    rdy();
    fop(A0, K_ARR);
    frd(A1, 8'hFF);
    frd(A0, 8'h5A);
    $display("test erase done");
    fop(A1, K_LOCK);
    fop(A1, K_SET);
    rdy();
    fop(A1, K_PROG);
    fop(A1, 8'h33);
    rdy();
    fop(A0, K_ARR);
    frd(A1, 8'hFF);
    apb(1'b1, OFS_CTRL, 32'h2);
    repeat (2) @(posedge pclk);
    chk(32'(pins.high_programming_voltage), 32'h1);
    fop(A1, K_PROG);
    fop(A1, 8'h33);
    rdy();
    fop(A0, K_ARR);
    frd(A1, 8'h33);
    apb(1'b1, OFS_CTRL, 32'h0);
    $display("test lock done");
    fop(A0 ^ 21'h00001, K_PROG);
    fop(A0 ^ 21'h00001, 8'h0F);
    fop(A0, K_ARR);
    rdy();
    frd(A0, K_RDY);
    $display("test busy done");
    apb(1'b1, OFS_CTRL, 32'h1);
    // Pin follows the control bit through two flops
    repeat (2) @(posedge pclk);
    chk(32'(pins.powerdown_reset_in), 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(r[3:2]), 32'h0);
    repeat (int'(C_PD) + 2) @(posedge pclk);
    apb(1'b1, OFS_CTRL, 32'h0);
    poll(ST_ROK_BIT, 1'b1);
    poll(ST_WOK_BIT, 1'b1);
    frd(A0 ^ 21'h00001, 8'h0F);
    $display("test power-down done");
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
    $display("test unmapped done");
    stop_test();
  end
endmodule // bfcs_ctrl_tb
`default_nettype wire
